// File: mo_pkg.sv
// Package for the modem option control block: register map, option field
// positions, reset values and timing counts.
// Assumes a 125 MHz system clock; all timers count a 1 ms tick.
package mo_pkg;

  localparam int unsigned SYS_CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS = 1_000_000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned HI_RATE_BPS = 1200;
  localparam int unsigned LO_RATE_BPS = 300;
  localparam int unsigned HI_HALF_CYCLES = SYS_CLK_HZ / (2 * HI_RATE_BPS);
  localparam int unsigned LO_HALF_CYCLES = SYS_CLK_HZ / (2 * LO_RATE_BPS);

  localparam int TIMER_W = 12;
  localparam int unsigned CARRIER_LOSS_MS = 350;
  localparam int unsigned LONG_SPACE_MS = 1600;
  localparam int unsigned SEND_SPACE_MS = 3000;
  // One tick past the figure, so the absence is strictly longer than it
  localparam logic [11:0] CARRIER_LOSS_TICKS = 12'(CARRIER_LOSS_MS + 1);
  localparam logic [11:0] LONG_SPACE_TICKS = 12'(LONG_SPACE_MS);
  localparam logic [11:0] SEND_SPACE_TICKS = 12'(SEND_SPACE_MS);

  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  localparam int CF_RX_TIMING = 0;
  localparam int CF_TX_TIMING = 1;
  localparam int CF_TT_SRC = 2;
  localparam int CF_SYNC = 4;
  localparam int CF_CHAR_NINE = 5;
  localparam int CF_RLOOP_IGNORE = 6;
  localparam int CF_CARRIER_LOSS = 7;
  localparam int CF_SEND_SPACE = 8;
  localparam int CF_LONG_SPACE = 9;
  localparam int CF_AUTO_ANSWER = 10;
  localparam int CF_HIGH_ONLY = 11;
  localparam int CF_SPEED_SEL = 12;
  localparam int CF_SPEED_IND = 13;
  localparam int CF_SPEED_PIN = 14;
  localparam int CF_RLOOP_CTRL = 16;
  localparam int CF_ALOOP_CTRL = 17;
  localparam int CF_RING_IND = 18;
  localparam int CF_TEST_IND = 19;
  localparam int CF_DSR_IN_ALOOP = 20;
  localparam int CF_CTS_COMMON = 21;
  localparam int CF_CD_FORCED = 22;
  localparam int CF_DSR_FORCED = 23;
  localparam int CF_CTS_FORCED = 24;
  localparam logic [31:0] CONFIG_RESET = 32'h0014_2780;
  localparam logic [31:0] CONFIG_MASK = 32'h01FF_FFFF;

  localparam int ST_CALL = 0;
  localparam int ST_HIGH = 1;
  localparam int ST_ALOOP = 2;
  localparam int ST_DLOOP = 3;
  localparam int ST_SYNC = 4;
  localparam int ST_CD = 5;
  localparam int ST_CFG_REJECT = 6;
  localparam int ST_SYNC_CONFLICT = 7;
  localparam int ST_SPACING = 8;

  localparam logic [1:0] TT_INTERNAL = 2'h0;
  localparam logic [1:0] TT_EXTERNAL = 2'h1;
  localparam logic [1:0] TT_SLAVE = 2'h2;
  localparam logic [1:0] SPIN_NORMAL = 2'h0;
  localparam logic [1:0] SPIN_ALTERNATE = 2'h1;

  typedef enum logic [1:0] {
    CALL_IDLE,
    CALL_ONLINE,
    CALL_SEND_SPACE
  } mo_call_e;

endpackage : mo_pkg

// File: mo_timer.sv
// Duration timer counting system ticks while a condition holds.
// Assumes tick is a one-cycle pulse in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module mo_timer #(
  parameter logic [11:0] LIMIT = 12'h001
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic tick, // Time base pulse
  input wire logic run, // Condition being timed
  output logic done // Condition held for LIMIT ticks
);
  logic [11:0] count;

  // Restarting at zero the moment run drops keeps bursts from adding up
  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      count <= 12'h000;
    end else if (tick && count != LIMIT) begin
      count <= count + 12'h001;
    end
  end

  assign done = run && (count == LIMIT);
endmodule : mo_timer
`default_nettype wire

// File: mo_clkgen.sv
// Square-wave bit clock made from the system clock by a half-period count.
// Assumes the clock only needs to be a sampled level, not a real clock net.
`timescale 1ns/1ps
`default_nettype none
module mo_clkgen #(
  parameter int unsigned HALF = 2
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  output logic bit_clk // Generated bit clock level
);
  logic [17:0] count;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count <= 18'h00000;
      bit_clk <= 1'b0;
    end else if (count == 18'(HALF - 1)) begin
      count <= 18'h00000;
      bit_clk <= ~bit_clk;
    end else begin
      count <= count + 18'h00001;
    end
  end
endmodule : mo_clkgen
`default_nettype wire

// File: mo_ctrl.sv
// Option control of the modem's terminal-side interface: timing sources,
// framing mode, call disconnect timers, answer, speed and loopback control,
// and the status leads toward the terminal. Registers over Avalon-MM.
// Assumes all modem and terminal inputs are synchronous to sys_clk.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module mo_ctrl #(
  parameter int unsigned TICK_CYC = mo_pkg::TICK_CYCLES,
  parameter int unsigned HI_HALF = mo_pkg::HI_HALF_CYCLES,
  parameter int unsigned LO_HALF = mo_pkg::LO_HALF_CYCLES
) (
  input wire logic sys_clk, // System clock, 125 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall until answer
  input wire logic ext_tx_clk, // Terminal-supplied transmit clock
  input wire logic rx_clk_rec, // Recovered receive clock
  input wire logic carrier_in, // Carrier detected on the line
  input wire logic rx_space, // Received line is spacing
  input wire logic line_high_speed, // Far modem answered at high rate
  input wire logic ring_in, // Ring detected on the line
  input wire logic term_ready, // Terminal ready, holds the call
  input wire logic modem_dsr, // Internal data-set-ready status
  input wire logic modem_cts, // Internal clear-to-send status
  input wire logic speed_select_in, // Terminal speed select lead
  input wire logic remote_loop_in, // Terminal remote loopback lead
  input wire logic analog_loop_in, // Terminal analog loopback lead
  input wire logic remote_loop_request, // Far modem asks for loopback
  output logic tx_clk, // Transmit clock to modulator
  output logic term_tx_clk, // Transmit clock to terminal
  output logic term_rx_clk, // Receive clock to terminal
  output logic sync_mode, // Synchronous framing active
  output logic char_ten_bits, // Ten-bit characters, else nine
  output logic off_hook, // Line seized for a call
  output logic tx_force_space, // Transmitter sends steady space
  output logic high_speed, // High-rate channel selected
  output logic low_channel_en, // Low-rate channel operative
  output logic remote_loop_send, // Ask far modem for loopback
  output logic digital_loop_mode, // Local digital loopback active
  output logic analog_loop_mode, // Analog loopback active
  output logic speed_ind_normal, // Speed indicator, normal lead
  output logic speed_ind_alt, // Speed indicator, alternate lead
  output logic ring_ind_out, // Ring indicate to terminal
  output logic test_mode_out, // Test indicator to terminal
  output logic carrier_detect, // Carrier detect to terminal
  output logic dsr_out, // Data set ready to terminal
  output logic cts_out // Clear to send to terminal
);
  import mo_pkg::*;

  logic [31:0] cfg;
  logic [31:0] next_cfg;
  logic cfg_reject;
  logic ack;
  logic [16:0] tick_cnt;
  logic tick;
  mo_call_e call_state;
  logic hi_clk;
  logic lo_clk;
  logic sync_req;
  logic sync_ok;
  logic loss_done;
  logic long_done;
  logic send_done;
  logic loss_run;
  logic long_run;
  logic in_test;
  logic end_call;
  logic [31:0] status;
  logic wr_cfg;
  logic wr_status;
  logic bad_cfg;
  logic [1:0] tt_src;
  logic [1:0] spin;

  // Avalon slave: one wait cycle, then a single answer cycle
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  // Writes land on the answer edge, the one where waitrequest is seen low
  assign wr_cfg = avs_write && ack && avs_address == ADDR_CONFIG;
  assign wr_status = avs_write && ack && avs_address == ADDR_STATUS;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  always_comb begin
    next_cfg = cfg;
    for (int i = 0; i < 4; i++) begin
      if (avs_byteenable[i]) begin
        next_cfg[i*8 +: 8] = avs_writedata[i*8 +: 8];
      end
    end
    next_cfg = next_cfg & CONFIG_MASK;
  end

  assign bad_cfg = next_cfg[CF_DSR_IN_ALOOP] && next_cfg[CF_DSR_FORCED];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg <= CONFIG_RESET;
    end else if (wr_cfg && !bad_cfg) begin
      cfg <= next_cfg;
    end
  end

  // Sticky until software writes one; a new reject in that cycle wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_reject <= 1'b0;
    end else if (wr_cfg && bad_cfg) begin
      cfg_reject <= 1'b1;
    end else if (wr_status && avs_byteenable[0] &&
                 avs_writedata[ST_CFG_REJECT]) begin
      cfg_reject <= 1'b0;
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[ST_CALL] = call_state != CALL_IDLE;
    status[ST_HIGH] = high_speed;
    status[ST_ALOOP] = analog_loop_mode;
    status[ST_DLOOP] = digital_loop_mode;
    status[ST_SYNC] = sync_mode;
    status[ST_CD] = carrier_detect;
    status[ST_CFG_REJECT] = cfg_reject;
    status[ST_SYNC_CONFLICT] = sync_req && !sync_ok;
    status[ST_SPACING] = tx_force_space;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      case (avs_address)
        ADDR_CONFIG: avs_readdata <= cfg;
        ADDR_STATUS: avs_readdata <= status;
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Millisecond tick from the master oscillator
  always_ff @(posedge sys_clk) begin
    if (reset || tick_cnt == 17'(TICK_CYC - 1)) begin
      tick_cnt <= 17'h00000;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 17'(TICK_CYC - 1);
    end
  end

  mo_clkgen #(.HALF(HI_HALF)) u_hi_clk (
    .sys_clk(sys_clk),
    .reset(reset),
    .bit_clk(hi_clk)
  );

  mo_clkgen #(.HALF(LO_HALF)) u_lo_clk (
    .sys_clk(sys_clk),
    .reset(reset),
    .bit_clk(lo_clk)
  );

  assign tt_src = cfg[CF_TT_SRC +: 2];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_clk <= 1'b0;
    end else begin
      case (tt_src)
        TT_INTERNAL: tx_clk <= high_speed ? hi_clk : lo_clk;
        TT_EXTERNAL: tx_clk <= ext_tx_clk;
        TT_SLAVE: tx_clk <= rx_clk_rec;
        default: tx_clk <= high_speed ? hi_clk : lo_clk;
      endcase
    end
  end

  // Outputs lag tx_clk and rx_clk_rec by one cycle; harmless at these bit rates
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      term_tx_clk <= 1'b0;
      term_rx_clk <= 1'b0;
    end else begin
      term_tx_clk <= cfg[CF_TX_TIMING] && tx_clk;
      term_rx_clk <= cfg[CF_RX_TIMING] && rx_clk_rec;
    end
  end

  // Sync asked for with a conflicting option falls back to async framing
  assign sync_req = cfg[CF_SYNC];
  assign sync_ok = cfg[CF_RX_TIMING] && cfg[CF_TX_TIMING] &&
                   !cfg[CF_SEND_SPACE] && !cfg[CF_LONG_SPACE];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_mode <= 1'b0;
      char_ten_bits <= 1'b1;
    end else begin
      sync_mode <= sync_req && sync_ok;
      char_ten_bits <= !cfg[CF_CHAR_NINE];
    end
  end

  // Speed choice
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      high_speed <= 1'b0;
      low_channel_en <= 1'b1;
    end else begin
      if (cfg[CF_HIGH_ONLY]) begin
        high_speed <= 1'b1;
      end else if (cfg[CF_SPEED_SEL]) begin
        high_speed <= speed_select_in;
      end else begin
        high_speed <= line_high_speed;
      end
      low_channel_en <= !cfg[CF_HIGH_ONLY];
    end
  end

  assign spin = cfg[CF_SPEED_PIN +: 2];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      speed_ind_normal <= 1'b0;
      speed_ind_alt <= 1'b0;
    end else begin
      speed_ind_normal <= cfg[CF_SPEED_IND] && high_speed &&
                          spin == SPIN_NORMAL;
      speed_ind_alt <= cfg[CF_SPEED_IND] && high_speed &&
                       spin == SPIN_ALTERNATE;
    end
  end

  // Loopback and test modes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      remote_loop_send <= 1'b0;
      analog_loop_mode <= 1'b0;
      digital_loop_mode <= 1'b0;
    end else begin
      remote_loop_send <= cfg[CF_RLOOP_CTRL] && remote_loop_in;
      analog_loop_mode <= cfg[CF_ALOOP_CTRL] && analog_loop_in;
      digital_loop_mode <= !cfg[CF_RLOOP_IGNORE] && remote_loop_request &&
                           call_state == CALL_ONLINE;
    end
  end

  assign in_test = remote_loop_send || analog_loop_mode || digital_loop_mode;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      test_mode_out <= 1'b0;
      ring_ind_out <= 1'b0;
    end else begin
      test_mode_out <= cfg[CF_TEST_IND] && in_test;
      ring_ind_out <= cfg[CF_RING_IND] && ring_in;
    end
  end

  // Terminal status leads
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      carrier_detect <= 1'b0;
      dsr_out <= 1'b0;
    end else begin
      carrier_detect <= cfg[CF_CD_FORCED] || carrier_in;
      dsr_out <= cfg[CF_DSR_FORCED] || modem_dsr ||
                 (cfg[CF_DSR_IN_ALOOP] && analog_loop_mode);
    end
  end

  // Uses the same next carrier value so with CF_CTS_COMMON set CTS never outlives carrier detect
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cts_out <= 1'b0;
    end else begin
      cts_out <= (cfg[CF_CTS_FORCED] || modem_cts) &&
                 (!cfg[CF_CTS_COMMON] ||
                  cfg[CF_CD_FORCED] || carrier_in);
    end
  end

  // Disconnect timers
  assign loss_run = cfg[CF_CARRIER_LOSS] && call_state == CALL_ONLINE &&
                    !carrier_in;
  assign long_run = cfg[CF_LONG_SPACE] && call_state == CALL_ONLINE &&
                    rx_space;

  mo_timer #(.LIMIT(CARRIER_LOSS_TICKS)) u_loss (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(tick),
    .run(loss_run),
    .done(loss_done)
  );

  mo_timer #(.LIMIT(LONG_SPACE_TICKS)) u_long (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(tick),
    .run(long_run),
    .done(long_done)
  );

  mo_timer #(.LIMIT(SEND_SPACE_TICKS)) u_send (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(tick),
    .run(call_state == CALL_SEND_SPACE),
    .done(send_done)
  );

  assign end_call = !term_ready || loss_done || long_done;

  // Call sequencing
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      call_state <= CALL_IDLE;
    end else begin
      case (call_state)
        CALL_IDLE: begin
          if (cfg[CF_AUTO_ANSWER] && ring_in && term_ready) begin
            call_state <= CALL_ONLINE;
          end
        end
        CALL_ONLINE: begin
          if (end_call) begin
            call_state <= cfg[CF_SEND_SPACE] ? CALL_SEND_SPACE
                                             : CALL_IDLE;
          end
        end
        CALL_SEND_SPACE: begin
          if (send_done) begin
            call_state <= CALL_IDLE;
          end
        end
        default: call_state <= CALL_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      off_hook <= 1'b0;
      tx_force_space <= 1'b0;
    end else begin
      off_hook <= call_state != CALL_IDLE;
      tx_force_space <= call_state == CALL_SEND_SPACE;
    end
  end
endmodule : mo_ctrl
`default_nettype wire

// File: mo_ctrl_chk.sv
// Checker for mo_ctrl: relations between its outputs and their causes.
// Assumes a CONFIG write takes effect at the edge with waitrequest low.
`timescale 1ns/1ps
`default_nettype none
module mo_ctrl_chk
  import mo_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic [3:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic avs_waitrequest, // Stall
  input wire logic carrier_in, // Line carrier
  input wire logic ring_in, // Line ring
  input wire logic carrier_detect, // CD out
  input wire logic dsr_out, // DSR out
  input wire logic cts_out, // CTS out
  input wire logic ring_ind_out, // Ring out
  input wire logic char_ten_bits, // Char length
  input wire logic test_mode_out, // Test out
  input wire logic sync_mode // Sync framing
);
  logic [31:0] cfg;

  // Shadow of CONFIG; a write asking for both DSR options is dropped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg <= CONFIG_RESET;
    end else if (avs_write && !avs_waitrequest && avs_address == ADDR_CONFIG
        && !(avs_writedata[20] && avs_writedata[23])) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i]) begin
          cfg[8*i +: 8] <= avs_writedata[8*i +: 8] & CONFIG_MASK[8*i +: 8];
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("waitrequest longer than one cycle");
  a_cd_forced: assert property (cfg[22] |=> carrier_detect)
    else $error("forced carrier detect not high");
  a_cd_follow: assert property (
    !cfg[22] |=> carrier_detect == $past(carrier_in))
    else $error("carrier detect does not follow carrier");
  a_dsr_forced: assert property (cfg[23] |=> dsr_out)
    else $error("forced DSR not high");
  a_cts_common: assert property (
    $past(cfg[21]) && !carrier_detect |-> !cts_out)
    else $error("CTS on while carrier detect off");
  a_ring_gate: assert property (
    ring_ind_out |-> $past(ring_in) && $past(cfg[18]))
    else $error("ring indicate passed without cause");
  a_char_len: assert property (cfg[5] |=> !char_ten_bits)
    else $error("nine-bit length not applied");
  a_test_gate: assert property (test_mode_out |-> $past(cfg[19]))
    else $error("test indicator while disabled");
  a_sync_needs: assert property (sync_mode |-> $past(cfg[4] && cfg[0]
    && cfg[1] && !cfg[8] && !cfg[9])) else $error("sync without its settings");

  c_ring: cover property (ring_ind_out);
  c_sync: cover property (sync_mode);
  c_common: cover property (cfg[21] && !carrier_detect);
endmodule : mo_ctrl_chk

bind mo_ctrl mo_ctrl_chk mo_ctrl_chk_inst (.*);
`default_nettype wire

// File: mo_term.sv
// Terminal-side partner: drives the terminal leads and its own tx clock.
// Assumes the bench states the wanted lead levels on want.
`timescale 1ns/1ps
`default_nettype none
module mo_term (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Sync reset
  input wire logic [3:0] want, // ready, speed, rloop, aloop
  output logic term_ready, // Terminal ready
  output logic speed_select_in, // Speed lead
  output logic remote_loop_in, // Remote loop lead
  output logic analog_loop_in, // Analog loop lead
  output logic ext_tx_clk // Terminal tx clock
);
  // Terminal oscillator runs free, so it toggles even between calls
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      term_ready <= 1'b0;
      speed_select_in <= 1'b0;
      remote_loop_in <= 1'b0;
      analog_loop_in <= 1'b0;
      ext_tx_clk <= 1'b0;
    end else begin
      term_ready <= want[0];
      speed_select_in <= want[1];
      remote_loop_in <= want[2];
      analog_loop_in <= want[3];
      ext_tx_clk <= ~ext_tx_clk;
    end
  end
endmodule : mo_term
`default_nettype wire

// File: mo_ctrl_tb.sv
// Self-checking bench for mo_ctrl with shortened timer parameters.
// Assumes mo_term stands in for the terminal on the control leads.
`timescale 1ns/1ps
`default_nettype none
module mo_ctrl_tb;
  import mo_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [3:0] want = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_read = 1'b0, avs_write = 1'b0, rx_clk_rec = 1'b0;
  logic carrier_in = 1'b0, rx_space = 1'b0, line_high_speed = 1'b0;
  logic ring_in = 1'b0, modem_dsr = 1'b0, modem_cts = 1'b0;
  logic remote_loop_request = 1'b0;
  logic avs_waitrequest, ext_tx_clk, term_ready, speed_select_in;
  logic remote_loop_in, analog_loop_in, tx_clk, term_tx_clk, term_rx_clk;
  logic sync_mode, char_ten_bits, off_hook, tx_force_space, high_speed;
  logic low_channel_en, remote_loop_send, digital_loop_mode;
  logic analog_loop_mode, speed_ind_normal, speed_ind_alt, ring_ind_out;
  logic test_mode_out, carrier_detect, dsr_out, cts_out;
  int err_total = 0;
  int n_tests = 0;

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rx_clk_rec <= ~rx_clk_rec;

  mo_term mo_term_inst (.sys_clk, .reset, .want, .term_ready,
    .speed_select_in, .remote_loop_in, .analog_loop_in, .ext_tx_clk);

  mo_ctrl #(.TICK_CYC(10), .HI_HALF(3), .LO_HALF(7)) mo_ctrl_inst (.*);

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tk

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // Read just after the edge: the values seen are those sampled there
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) err_total++;
    @(posedge sys_clk);
  endtask : bus

  task automatic set_cfg(input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ADDR_CONFIG, d, q);
    tk(4);
  endtask : set_cfg

  task automatic t_defaults;
    logic [31:0] q;
    bus(1'b0, ADDR_CONFIG, 32'h0, q);
    chk("config", q, CONFIG_RESET);
    chk("ten_bits", char_ten_bits, 1'b1);
    chk("low_chan", low_channel_en, 1'b1);
    bus(1'b0, 4'h8, 32'h0, q);
    chk("unmapped", q, 32'h0);
    set_cfg(32'h0000_0020);
    chk("nine_bits", char_ten_bits, 1'b0);
    chk("rx_clk_off", term_rx_clk, 1'b0);
    chk("tx_clk_off", term_tx_clk, 1'b0);
  endtask : t_defaults

  task automatic t_leads;
    logic [31:0] q;
    modem_cts <= 1'b1;
    set_cfg(32'h01C0_0000);
    chk("cd_forced", carrier_detect, 1'b1);
    chk("dsr_forced", dsr_out, 1'b1);
    chk("cts_forced", cts_out, 1'b1);
    set_cfg(32'h0020_0000);
    chk("cd_normal", carrier_detect, 1'b0);
    chk("cts_common", cts_out, 1'b0);
    carrier_in <= 1'b1;
    tk(4);
    chk("cd_follow", carrier_detect, 1'b1);
    chk("cts_on", cts_out, 1'b1);
    chk("dsr_follow", dsr_out, 1'b0);
    modem_dsr <= 1'b1;
    tk(3);
    chk("dsr_on", dsr_out, 1'b1);
    modem_dsr <= 1'b0;
    bus(1'b1, ADDR_CONFIG, 32'h0090_0000, q);
    bus(1'b0, ADDR_CONFIG, 32'h0, q);
    chk("cfg_kept", q, 32'h0020_0000);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk("reject_set", q[6], 1'b1);
    bus(1'b1, ADDR_STATUS, 32'h40, q);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk("reject_clr", q[6], 1'b0);
    carrier_in <= 1'b0;
  endtask : t_leads

  task automatic t_ring;
    set_cfg(32'h0004_0000);
    ring_in <= 1'b1;
    want <= 4'h1;
    tk(4);
    chk("ring_on", ring_ind_out, 1'b1);
    chk("no_answer", off_hook, 1'b0);
    set_cfg(32'h0);
    chk("ring_off", ring_ind_out, 1'b0);
    ring_in <= 1'b0;
  endtask : t_ring

  task automatic t_call;
    int n;
    set_cfg(32'h0000_0580);
    carrier_in <= 1'b1;
    ring_in <= 1'b1;
    tk(6);
    chk("answered", off_hook, 1'b1);
    remote_loop_request <= 1'b1;
    tk(3);
    chk("dloop", digital_loop_mode, 1'b1);
    set_cfg(32'h0000_05C0);
    chk("dloop_ign", digital_loop_mode, 1'b0);
    remote_loop_request <= 1'b0;
    ring_in <= 1'b0;
    carrier_in <= 1'b0;
    tk(2000);
    chk("held", off_hook, 1'b1);
    carrier_in <= 1'b1;
    tk(5);
    carrier_in <= 1'b0;
    n = 0;
    while (tx_force_space !== 1'b1 && n < 4000) begin
      tk(1);
      n++;
    end
    chk("loss_time", n >= 3495 && n <= 3530, 1'b1);
    n = 0;
    while (off_hook !== 1'b0 && n < 31000) begin
      tk(1);
      n++;
    end
    chk("space_time", n >= 29985 && n <= 30025, 1'b1);
    tk(2);
    chk("space_end", tx_force_space, 1'b0);
    set_cfg(32'h0000_0600);
    ring_in <= 1'b1;
    tk(6);
    chk("answer2", off_hook, 1'b1);
    ring_in <= 1'b0;
    rx_space <= 1'b1;
    n = 0;
    while (off_hook !== 1'b0 && n < 17000) begin
      tk(1);
      n++;
    end
    chk("long_time", n >= 15990 && n <= 16010, 1'b1);
    rx_space <= 1'b0;
    want <= 4'h0;
  endtask : t_call

  task automatic t_speed;
    set_cfg(32'h0000_3000);
    want <= 4'h2;
    tk(4);
    chk("sel_high", high_speed, 1'b1);
    chk("ind_high", speed_ind_normal, 1'b1);
    set_cfg(32'h0000_7000);
    chk("ind_alt", speed_ind_alt, 1'b1);
    chk("ind_norm_off", speed_ind_normal, 1'b0);
    want <= 4'h0;
    set_cfg(32'h0000_3000);
    chk("sel_low", high_speed, 1'b0);
    chk("ind_low", speed_ind_normal, 1'b0);
    set_cfg(32'h0000_0800);
    chk("hi_only", high_speed, 1'b1);
    chk("lo_off", low_channel_en, 1'b0);
  endtask : t_speed

  task automatic t_loop;
    logic [31:0] q;
    set_cfg(32'h001B_0000);
    want <= 4'hC;
    tk(4);
    chk("aloop", analog_loop_mode, 1'b1);
    chk("rloop_send", remote_loop_send, 1'b1);
    chk("test_ind", test_mode_out, 1'b1);
    chk("dsr_aloop", dsr_out, 1'b1);
    set_cfg(32'h0);
    chk("aloop_off", analog_loop_mode, 1'b0);
    chk("rloop_off", remote_loop_send, 1'b0);
    want <= 4'h0;
    set_cfg(32'h0000_0017);
    chk("sync_on", sync_mode, 1'b1);
    chk("rx_clk_out", term_rx_clk, !rx_clk_rec);
    chk("tx_ext", tx_clk, !ext_tx_clk);
    tk(1);
    chk("tx_ext_2", tx_clk, !ext_tx_clk);
    chk("tx_clk_out", term_tx_clk, ext_tx_clk);
    set_cfg(32'h0000_0113);
    chk("sync_off", sync_mode, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk("sync_conf", q[7], 1'b1);
  endtask : t_loop

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    #700000;
    err_total++;
    end_sim();
  end

  initial begin
    tk(16);
    reset <= 1'b0;
    tk(1);
    t_defaults();
    t_leads();
    t_ring();
    t_call();
    t_speed();
    t_loop();
    end_sim();
  end
endmodule : mo_ctrl_tb
`default_nettype wire
